// file: trace_debug_pkg.sv
// Shared constants for the trace debug trigger block
package trace_debug_pkg;

  // ==========================================
  // Trigger mode encodings
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVENT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  localparam int MODE_W = 4;

  // ==========================================
  // Capture modes
  localparam logic [1:0] CAP_NORMAL = 2'h0;
  localparam logic [1:0] CAP_LOOP1 = 2'h1;
  localparam logic [1:0] CAP_DETAIL = 2'h2;
  localparam logic [1:0] CAP_PROFILE = 2'h3;
  localparam int CAP_W = 2;

  // ==========================================
  // Paging and trace buffer
  localparam logic [1:0] PAGE_EXTENDED = 2'h1;
  localparam int PAGE_W = 2;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int EXT_W = 8;
  localparam int BUF_DEPTH = 64;
  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int CNT_W = PTR_W + 1;

  // ==========================================
  // Mode classification
  function automatic logic is_event_mode(input logic [3:0] mode);
    is_event_mode = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
  endfunction

endpackage

// file: bus_comparator.sv
// One address or data comparator on the core bus
`timescale 1ns/10ps
module bus_comparator #(
  parameter int ADDR_W = 16,
  parameter int EXT_W = 8
) (
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [EXT_W-1:0] bus_ext_i,
  input wire logic [ADDR_W-1:0] bus_data_i,
  input wire logic bus_rw_i,
  input wire logic bus_valid_i,
  input wire logic [ADDR_W-1:0] ref_value_i,
  input wire logic [EXT_W-1:0] ref_ext_i,
  input wire logic compare_data_i,
  input wire logic page_match_i,
  input wire logic rw_enable_i,
  input wire logic rw_select_i,
  output logic hit_o
);

  // ==========================================
  // Match terms
  logic value_hit;
  logic ext_hit;
  logic rw_hit;

  // Data compares ignore the upper page bits
  assign value_hit = compare_data_i ? (bus_data_i == ref_value_i) : (bus_addr_i == ref_value_i);
  assign ext_hit = compare_data_i || !page_match_i || (bus_ext_i == ref_ext_i);
  assign rw_hit = !rw_enable_i || (bus_rw_i == rw_select_i);
  assign hit_o = bus_valid_i && value_hit && ext_hit && rw_hit;

endmodule // bus_comparator

// file: debug_trigger_comparators.sv
// Comparators and trace buffer trigger control of the trace debug unit
// What this block does
// - Comparator A matches address against its registers
// - Comparator B matches data in full mode
// - Page select 01 adds extended address match
// - Tagged C breakpoint beats tagged A/B trigger
// - Tag select ignores read/write qualify enables
// - Full mode (A and B only) qualifies both by A rw bits
// - Full mode data compare follows rw table
// - Tag select waits for opcode tracking
// - Controller decides storing and break requests
// - Begin trigger stores until 64 filled
// - End trigger overwrites oldest beyond 64
// - Debug enable plus arm starts evaluation
// - Arm clears at end trigger, or at full after a begin trigger
// - Modes 0-5 decoded, 6-8 never fire; matches set A/B flags
// - Arming clears A, B, C flags
// - Store flow, event data or detail
// - A only and A or B triggering
// - A then B triggers on later B
// - Event B is begin type, untagged
// - A then event B retriggers per B
// - Detail capture overrides event-only modes
// - A and B need same-cycle match untagged; tagged A and B fires on A alone
// - Breakpoint mode or secure blocks trace
`timescale 1ns/10ps
module debug_trigger_comparators #(
  parameter int ADDR_W = trace_debug_pkg::ADDR_W,
  parameter int EXT_W = trace_debug_pkg::EXT_W,
  parameter int BUF_DEPTH = trace_debug_pkg::BUF_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic debug_enable_bit_i,
  input wire logic breakpoint_mode_enable_i,
  input wire logic secured_i,
  input wire logic arm_set_i,
  input wire logic arm_clear_i,
  input wire logic [trace_debug_pkg::MODE_W-1:0] trigger_mode_i,
  input wire logic [trace_debug_pkg::CAP_W-1:0] capture_mode_i,
  input wire logic begin_select_i,
  input wire logic tag_select_i,
  input wire logic break_enable_i,
  input wire logic [trace_debug_pkg::PAGE_W-1:0] page_select_field_i,
  input wire logic [ADDR_W-1:0] comparator_a_address_i,
  input wire logic [EXT_W-1:0] comparator_a_extended_i,
  input wire logic [ADDR_W-1:0] comparator_b_value_i,
  input wire logic [EXT_W-1:0] comparator_b_extended_i,
  input wire logic [ADDR_W-1:0] comparator_c_address_i,
  input wire logic [EXT_W-1:0] comparator_c_extended_i,
  input wire logic comp_a_rw_qualify_enable_i,
  input wire logic comp_a_rw_select_i,
  input wire logic comp_b_rw_qualify_enable_i,
  input wire logic comp_b_rw_select_i,
  input wire logic comp_c_enable_i,
  input wire logic comp_c_tag_i,
  input wire logic [ADDR_W-1:0] core_addr_i,
  input wire logic [EXT_W-1:0] core_ext_i,
  input wire logic [ADDR_W-1:0] core_data_i,
  input wire logic core_rw_i,
  input wire logic core_valid_i,
  input wire logic core_fetch_i,
  input wire logic core_free_i,
  input wire logic flow_valid_i,
  input wire logic [ADDR_W-1:0] flow_addr_i,
  input wire logic tag_a_exec_i,
  input wire logic tag_b_exec_i,
  input wire logic tag_c_exec_i,
  output logic tag_a_req_o,
  output logic tag_b_req_o,
  output logic tag_c_req_o,
  output logic armed_o,
  output logic flag_a_o,
  output logic flag_b_o,
  output logic flag_c_o,
  output logic triggered_o,
  output logic buffer_full_o,
  output logic store_valid_o,
  output logic [ADDR_W-1:0] store_data_o,
  output logic [$clog2(BUF_DEPTH)-1:0] store_ptr_o,
  output logic [$clog2(BUF_DEPTH):0] store_count_o,
  output logic break_req_o
);

  localparam int PW = $clog2(BUF_DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(BUF_DEPTH);

  typedef enum logic [1:0] {ph_idle, ph_before, ph_after} phase_type;

  // ==========================================
  // Mode decode
  logic active;
  logic detail;
  logic event_raw;
  logic event_eff;
  logic full_mode;
  logic begin_eff;
  logic tag_a_eff;
  logic tag_b_eff;
  logic rw_en_a;
  logic rw_en_b;
  logic rw_sel_b;
  logic page_match;
  logic [trace_debug_pkg::MODE_W-1:0] mode_eff;

  assign active = debug_enable_bit_i && !breakpoint_mode_enable_i && !secured_i;
  assign detail = capture_mode_i == trace_debug_pkg::CAP_DETAIL;
  assign event_raw = trace_debug_pkg::is_event_mode(trigger_mode_i);
  assign event_eff = event_raw && !detail;
  assign full_mode = trigger_mode_i == trace_debug_pkg::MODE_A_AND_B;
  assign page_match = page_select_field_i == trace_debug_pkg::PAGE_EXTENDED;

  // Detail capture folds A then event B onto A then B and keeps event B as it is
  always_comb begin
    mode_eff = trigger_mode_i;
    if (detail && trigger_mode_i == trace_debug_pkg::MODE_EVENT_B) begin
      mode_eff = trace_debug_pkg::MODE_EVENT_B;
    end else if (detail && trigger_mode_i == trace_debug_pkg::MODE_A_THEN_EVENT_B) begin
      mode_eff = trace_debug_pkg::MODE_A_THEN_B;
    end
  end

  assign begin_eff = begin_select_i || event_eff;
  assign tag_a_eff = tag_select_i && !(event_eff && trigger_mode_i == trace_debug_pkg::MODE_EVENT_B);
  assign tag_b_eff = tag_select_i && !event_eff;

  // Rw qualification makes no sense on tagged opcode reads
  assign rw_en_a = comp_a_rw_qualify_enable_i && !tag_select_i;
  assign rw_en_b = (full_mode ? comp_a_rw_qualify_enable_i : comp_b_rw_qualify_enable_i) && !tag_select_i;
  assign rw_sel_b = full_mode ? comp_a_rw_select_i : comp_b_rw_select_i;

  // ==========================================
  // Comparators
  logic match_a;
  logic match_b;
  logic match_c;

  bus_comparator #(.ADDR_W(ADDR_W), .EXT_W(EXT_W)) u_comp_a (
    .bus_addr_i(core_addr_i),
    .bus_ext_i(core_ext_i),
    .bus_data_i(core_data_i),
    .bus_rw_i(core_rw_i),
    .bus_valid_i(core_valid_i),
    .ref_value_i(comparator_a_address_i),
    .ref_ext_i(comparator_a_extended_i),
    .compare_data_i(1'b0),
    .page_match_i(page_match),
    .rw_enable_i(rw_en_a),
    .rw_select_i(comp_a_rw_select_i),
    .hit_o(match_a)
  );

  bus_comparator #(.ADDR_W(ADDR_W), .EXT_W(EXT_W)) u_comp_b (
    .bus_addr_i(core_addr_i),
    .bus_ext_i(core_ext_i),
    .bus_data_i(core_data_i),
    .bus_rw_i(core_rw_i),
    .bus_valid_i(core_valid_i),
    .ref_value_i(comparator_b_value_i),
    .ref_ext_i(comparator_b_extended_i),
    .compare_data_i(full_mode),
    .page_match_i(page_match),
    .rw_enable_i(rw_en_b),
    .rw_select_i(rw_sel_b),
    .hit_o(match_b)
  );

  bus_comparator #(.ADDR_W(ADDR_W), .EXT_W(EXT_W)) u_comp_c (
    .bus_addr_i(core_addr_i),
    .bus_ext_i(core_ext_i),
    .bus_data_i(core_data_i),
    .bus_rw_i(core_rw_i),
    .bus_valid_i(core_valid_i),
    .ref_value_i(comparator_c_address_i),
    .ref_ext_i(comparator_c_extended_i),
    .compare_data_i(1'b0),
    .page_match_i(page_match),
    .rw_enable_i(1'b0),
    .rw_select_i(1'b0),
    .hit_o(match_c)
  );

  // ==========================================
  // Tagging and hits
  phase_type phase_r;
  logic armed;
  logic c_tag_hit;
  logic c_force_hit;
  logic hit_a;
  logic hit_b;

  assign armed = phase_r != ph_idle;
  assign c_tag_hit = comp_c_enable_i && comp_c_tag_i && tag_c_exec_i;
  assign c_force_hit = comp_c_enable_i && !comp_c_tag_i && match_c;

  // Tag requests go to the opcode tracker, which answers on execution
  assign tag_a_req_o = armed && tag_a_eff && match_a;
  assign tag_b_req_o = armed && tag_b_eff && match_b;
  assign tag_c_req_o = comp_c_enable_i && comp_c_tag_i && match_c;

  assign hit_a = armed && (tag_a_eff ? (tag_a_exec_i && !c_tag_hit) : match_a);
  assign hit_b = armed && (tag_b_eff ? (tag_b_exec_i && !c_tag_hit) : match_b);

  // ==========================================
  // Trigger decision
  logic a_seen_r;
  logic set_a;
  logic set_b;
  logic fire;

  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    fire = 1'b0;
    case (mode_eff)
      trace_debug_pkg::MODE_A_ONLY: begin
        set_a = hit_a;
        fire = hit_a;
      end
      trace_debug_pkg::MODE_A_OR_B: begin
        set_a = hit_a;
        set_b = hit_b;
        fire = hit_a || hit_b;
      end
      trace_debug_pkg::MODE_A_THEN_B, trace_debug_pkg::MODE_A_THEN_EVENT_B: begin
        set_a = hit_a;
        set_b = hit_b && a_seen_r;
        fire = hit_b && a_seen_r;
      end
      trace_debug_pkg::MODE_EVENT_B: begin
        set_b = hit_b;
        fire = hit_b;
      end
      trace_debug_pkg::MODE_A_AND_B: begin
        // Tagged full mode drops the data side entirely
        if (tag_select_i) begin
          set_a = hit_a;
          fire = hit_a;
        end else begin
          set_a = hit_a && hit_b;
          set_b = hit_a && hit_b;
          fire = hit_a && hit_b;
        end
      end
      default: begin
        fire = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a_seen_r <= 1'b0;
    end else if (set_a) begin
      a_seen_r <= 1'b1;
    end else if (arm_set_i) begin
      a_seen_r <= 1'b0;
    end
  end

  // ==========================================
  // Storage selection
  logic store_now;
  logic [ADDR_W-1:0] store_word;
  logic detail_pend_r;
  logic [ADDR_W-1:0] detail_data_r;
  logic take;
  logic [PW:0] count_r;
  logic [PW-1:0] ptr_r;
  logic full;
  logic end_hit;

  assign full = count_r == FULL_COUNT;
  assign end_hit = phase_r == ph_before && !begin_eff && fire;
  assign take = (phase_r == ph_after) || (phase_r == ph_before && !begin_eff && !fire);

  always_comb begin
    store_now = 1'b0;
    store_word = flow_addr_i;
    if (detail) begin
      // Data word of a detail pair goes out one cycle after its address
      if (detail_pend_r) begin
        store_now = 1'b1;
        store_word = detail_data_r;
      end else if (core_valid_i && !core_fetch_i && !core_free_i) begin
        store_now = 1'b1;
        store_word = core_addr_i;
      end
    end else if (event_eff) begin
      store_now = fire;
      store_word = core_data_i;
    end else begin
      store_now = flow_valid_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      detail_pend_r <= 1'b0;
      detail_data_r <= '0;
    end else begin
      detail_pend_r <= detail && !detail_pend_r && store_now && take;
      if (detail && !detail_pend_r) begin
        detail_data_r <= core_data_i;
      end
    end
  end

  // ==========================================
  // Arming sequence
  logic begin_trig;
  logic last_store;

  assign begin_trig = phase_r == ph_before && begin_eff && fire;
  assign last_store = phase_r == ph_after && store_now && count_r == FULL_COUNT - 1'b1;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_r <= ph_idle;
    end else begin
      case (phase_r)
        ph_idle: begin
          if (arm_set_i && active) begin
            phase_r <= ph_before;
          end
        end
        ph_before: begin
          if (!active || arm_clear_i) begin
            phase_r <= ph_idle;
          end else if (end_hit) begin
            phase_r <= ph_idle;
          end else if (begin_trig) begin
            phase_r <= ph_after;
          end
        end
        ph_after: begin
          if (!active || arm_clear_i || last_store) begin
            phase_r <= ph_idle;
          end
        end
        default: begin
          phase_r <= ph_idle;
        end
      endcase
    end
  end

  // ==========================================
  // Flags
  logic flag_a_r;
  logic flag_b_r;
  logic flag_c_r;
  logic trig_r;

  // A hit in the arming cycle survives the clear
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
      flag_c_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      flag_a_r <= (flag_a_r && !arm_set_i) || set_a;
      flag_b_r <= (flag_b_r && !arm_set_i) || set_b;
      flag_c_r <= (flag_c_r && !arm_set_i) || (armed && (c_tag_hit || c_force_hit));
      trig_r <= (trig_r && !arm_set_i) || (armed && fire);
    end
  end

  // ==========================================
  // Trace buffer write side
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_r <= '0;
      count_r <= '0;
      store_valid_o <= 1'b0;
      store_data_o <= '0;
      store_ptr_o <= '0;
    end else begin
      store_valid_o <= 1'b0;
      if (arm_set_i && !armed) begin
        ptr_r <= '0;
        count_r <= '0;
      end else if (store_now && take && !(phase_r == ph_after && full)) begin
        store_valid_o <= 1'b1;
        store_data_o <= store_word;
        store_ptr_o <= ptr_r;
        ptr_r <= ptr_r + 1'b1;
        if (!full) begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Break requests
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      break_req_o <= 1'b0;
    end else begin
      break_req_o <= (break_enable_i && (end_hit || last_store)) || c_tag_hit || c_force_hit;
    end
  end

  assign armed_o = armed;
  assign flag_a_o = flag_a_r;
  assign flag_b_o = flag_b_r;
  assign flag_c_o = flag_c_r;
  assign triggered_o = trig_r;
  assign buffer_full_o = full;
  assign store_count_o = count_r;

endmodule // debug_trigger_comparators

// file: cpu_core_model.sv
// Core bus and opcode tracker stand-in for the trigger block
`timescale 1ns/10ps
module cpu_core_model (
  input wire logic mclk_i,
  input wire logic tag_a_req_i,
  input wire logic tag_b_req_i,
  input wire logic tag_c_req_i,
  output logic [15:0] core_addr_o,
  output logic [7:0] core_ext_o,
  output logic [15:0] core_data_o,
  output logic core_rw_o,
  output logic core_valid_o,
  output logic [2:0] tag_exec_o
);
  logic [2:0] req_d1_r = 3'h0;
  logic [2:0] req_d2_r = 3'h0;
  initial begin
    core_addr_o = 16'h0;
    core_ext_o = 8'h0;
    core_data_o = 16'h0;
    core_rw_o = 1'b1;
    core_valid_o = 1'b0;
    tag_exec_o = 3'h0;
  end
  // ==========================================
  // Bus cycle: one clock, then a clock of inverted junk
  task automatic bus_cycle(input logic [15:0] a, input logic [15:0] d, input logic rw, input logic [7:0] x);
    core_addr_o = a;
    core_data_o = d;
    core_rw_o = rw;
    core_ext_o = x;
    core_valid_o = 1'b1;
    @(negedge mclk_i);
    core_addr_o = ~a;
    core_data_o = ~d;
    core_ext_o = ~x;
    core_valid_o = 1'b0;
    @(negedge mclk_i);
  endtask
  // ==========================================
  // Tagged opcode reaches execute a few edges after its hit
  always @(posedge mclk_i) begin
    req_d1_r <= {tag_c_req_i, tag_b_req_i, tag_a_req_i};
    req_d2_r <= req_d1_r;
  end
  always @(negedge mclk_i) begin
    tag_exec_o <= req_d2_r;
  end
endmodule // cpu_core_model

// file: trace_trigger_props.sv
// Checker of arming, trigger, flag and storage relations
`timescale 1ns/10ps
module trace_trigger_props #(
  parameter int BUF_DEPTH = 64
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic debug_enable_bit_i,
  input wire logic breakpoint_mode_enable_i,
  input wire logic secured_i,
  input wire logic arm_set_i,
  input wire logic arm_clear_i,
  input wire logic [3:0] trigger_mode_i,
  input wire logic begin_select_i,
  input wire logic tag_select_i,
  input wire logic [1:0] page_select_field_i,
  input wire logic [15:0] comparator_a_address_i,
  input wire logic comp_a_rw_qualify_enable_i,
  input wire logic [15:0] core_addr_i,
  input wire logic core_valid_i,
  input wire logic tag_a_exec_i,
  input wire logic tag_b_exec_i,
  input wire logic tag_c_exec_i,
  input wire logic armed_o,
  input wire logic flag_a_o,
  input wire logic flag_b_o,
  input wire logic flag_c_o,
  input wire logic triggered_o,
  input wire logic buffer_full_o,
  input wire logic store_valid_o,
  input wire logic [$clog2(BUF_DEPTH):0] store_count_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // Comparator A hit, then forced A-only qualification
  sequence s_a_hit;
    armed_o && core_valid_i && core_addr_i == comparator_a_address_i && page_select_field_i != 2'h1;
  endsequence
  sequence s_a_force;
    s_a_hit ##0 (trigger_mode_i == 4'h0 && !tag_select_i && !comp_a_rw_qualify_enable_i);
  endsequence
  property p_force_a;
    s_a_force |=> flag_a_o && triggered_o;
  endproperty
  a_force_a: assert property (p_force_a) else $error("forced A match gave no trigger");
  property p_flag_hold;
    flag_a_o && !arm_set_i |=> flag_a_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag A dropped without arming");
  property p_arm_clear;
    arm_set_i && !core_valid_i && !tag_a_exec_i && !tag_b_exec_i && !tag_c_exec_i
      |=> !flag_a_o && !flag_b_o && !flag_c_o && !triggered_o;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arming left flags set");
  property p_arm_start;
    arm_set_i && debug_enable_bit_i && !breakpoint_mode_enable_i && !secured_i && !arm_clear_i && !armed_o
      |=> armed_o;
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("arm request not taken");
  property p_blocked;
    !armed_o && (breakpoint_mode_enable_i || secured_i || !debug_enable_bit_i) |=> !armed_o;
  endproperty
  a_blocked: assert property (p_blocked) else $error("armed while trace mode blocked");
  property p_full;
    buffer_full_o == (store_count_o == BUF_DEPTH);
  endproperty
  a_full: assert property (p_full) else $error("full flag disagrees with count");
  property p_count;
    store_count_o <= BUF_DEPTH;
  endproperty
  a_count: assert property (p_count) else $error("store count above depth");
  property p_end_disarm;
    $rose(triggered_o) && !begin_select_i && trigger_mode_i < 4'h3 |-> !armed_o;
  endproperty
  a_end_disarm: assert property (p_end_disarm) else $error("end trigger left unit armed");
  property p_idle_store;
    !armed_o |=> !store_valid_o;
  endproperty
  a_idle_store: assert property (p_idle_store) else $error("store while disarmed");
  property p_then_b;
    armed_o && trigger_mode_i == 4'h2 && !flag_a_o && !triggered_o && !tag_a_exec_i
      && core_addr_i != comparator_a_address_i |=> !triggered_o;
  endproperty
  a_then_b: assert property (p_then_b) else $error("B triggered before A");
endmodule // trace_trigger_props
bind debug_trigger_comparators trace_trigger_props #(.BUF_DEPTH(BUF_DEPTH)) i_trace_trigger_props (.*);

// file: debug_trigger_comparators_tb.sv
// Self-checking bench of the trace trigger comparators
`timescale 1ns/10ps
module debug_trigger_comparators_tb;
  logic mclk_i;
  logic nrst_i = 1'b0;
  logic debug_enable_bit_i = 1'b1, breakpoint_mode_enable_i = 1'b0, secured_i = 1'b0;
  logic arm_set_i = 1'b0, arm_clear_i = 1'b0, begin_select_i = 1'b0, tag_select_i = 1'b0;
  logic break_enable_i = 1'b0, comp_c_enable_i = 1'b0, comp_c_tag_i = 1'b1;
  logic comp_a_rw_qualify_enable_i = 1'b0, comp_a_rw_select_i = 1'b0;
  logic comp_b_rw_qualify_enable_i = 1'b0, comp_b_rw_select_i = 1'b0;
  logic core_fetch_i = 1'b0, core_free_i = 1'b0, flow_valid_i = 1'b0;
  logic [3:0] trigger_mode_i = 4'h0;
  logic [1:0] capture_mode_i = 2'h0, page_select_field_i = 2'h0;
  logic [15:0] comparator_a_address_i = 16'h1000, comparator_b_value_i = 16'h2000;
  logic [15:0] comparator_c_address_i = 16'h3000, flow_addr_i = 16'h0abc;
  logic [7:0] comparator_a_extended_i = 8'h05, comparator_b_extended_i = 8'h06, comparator_c_extended_i = 8'h07;
  logic [15:0] core_addr_i, core_data_i, store_data_o, last_store;
  logic [7:0] core_ext_i;
  logic [2:0] tag_exec;
  logic core_rw_i, core_valid_i, tag_a_exec_i, tag_b_exec_i, tag_c_exec_i;
  logic tag_a_req_o, tag_b_req_o, tag_c_req_o, armed_o, flag_a_o, flag_b_o, flag_c_o;
  logic triggered_o, buffer_full_o, store_valid_o, break_req_o;
  logic brk_seen = 1'b0;
  logic [5:0] store_ptr_o;
  logic [6:0] store_count_o;
  int n_fail = 0, n_checks = 0;
  assign {tag_c_exec_i, tag_b_exec_i, tag_a_exec_i} = tag_exec;
  debug_trigger_comparators i_debug_trigger_comparators (.*);
  cpu_core_model i_cpu_core_model (
    .mclk_i(mclk_i),
    .tag_a_req_i(tag_a_req_o),
    .tag_b_req_i(tag_b_req_o),
    .tag_c_req_i(tag_c_req_o),
    .core_addr_o(core_addr_i),
    .core_ext_o(core_ext_i),
    .core_data_o(core_data_i),
    .core_rw_o(core_rw_i),
    .core_valid_o(core_valid_i),
    .tag_exec_o(tag_exec)
  );
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // Break is a one-cycle pulse, so latch it
  always @(posedge mclk_i) begin
    if (store_valid_o === 1'b1) last_store <= store_data_o;
    if (arm_set_i === 1'b1) brk_seen <= 1'b0;
    else if (break_req_o === 1'b1) brk_seen <= 1'b1;
  end
  // ==========================================
  // Tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic arm();
    arm_set_i = 1'b1;
    tick(1);
    arm_set_i = 1'b0;
    tick(1);
  endtask
  task automatic cyc(input logic [15:0] a, input logic [15:0] d = 16'h0, input logic rw = 1'b1,
                     input logic [7:0] x = 8'h05);
    i_cpu_core_model.bus_cycle(a, d, rw, x);
  endtask
  task automatic flows(input int n);
    flow_valid_i = 1'b1;
    tick(n);
    flow_valid_i = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles
  initial begin
    #1000000;
    n_fail++;
    wrap_up();
  end
  // ==========================================
  // Scenarios
  initial begin
    tick(3);
    nrst_i = 1'b1;
    arm();
    check("armed", armed_o, 1'h1);
    cyc(16'h1000);
    check("flag_a", flag_a_o, 1'h1);
    check("trig", triggered_o, 1'h1);
    check("end_disarm", armed_o, 1'h0);
    tick(5);
    check("flag_hold", flag_a_o, 1'h1);
    arm();
    check("flag_clr", flag_a_o, 1'h0);
    trigger_mode_i = 4'h1;
    cyc(16'h2000);
    check("or_flag_b", flag_b_o, 1'h1);
    check("or_flag_a", flag_a_o, 1'h0);
    check("or_trig", triggered_o, 1'h1);
    trigger_mode_i = 4'h2;
    arm();
    cyc(16'h2000);
    check("tb_early", triggered_o, 1'h0);
    cyc(16'h1000);
    check("tb_a", flag_a_o, 1'h1);
    cyc(16'h2000);
    check("tb_trig", triggered_o, 1'h1);
    trigger_mode_i = 4'h5;
    arm();
    cyc(16'h1000, 16'h1234);
    check("ab_data", triggered_o, 1'h0);
    comp_a_rw_qualify_enable_i = 1'b1;
    comp_a_rw_select_i = 1'b1;
    comp_b_rw_qualify_enable_i = 1'b1;
    cyc(16'h1000, 16'h2000, 1'b0);
    check("ab_write", triggered_o, 1'h0);
    cyc(16'h1000, 16'h2000, 1'b1);
    check("ab_trig", triggered_o, 1'h1);
    check("ab_flag_b", flag_b_o, 1'h1);
    comp_b_rw_qualify_enable_i = 1'b0;
    trigger_mode_i = 4'h0;
    comp_a_rw_qualify_enable_i = 1'b0;
    page_select_field_i = 2'h1;
    arm();
    cyc(16'h1000, 16'h0, 1'b1, 8'h04);
    check("page_miss", flag_a_o, 1'h0);
    cyc(16'h1000);
    check("page_hit", flag_a_o, 1'h1);
    page_select_field_i = 2'h0;
    breakpoint_mode_enable_i = 1'b1;
    arm();
    check("bkp_block", armed_o, 1'h0);
    breakpoint_mode_enable_i = 1'b0;
    secured_i = 1'b1;
    arm();
    check("sec_block", armed_o, 1'h0);
    secured_i = 1'b0;
    tag_select_i = 1'b1;
    comp_a_rw_qualify_enable_i = 1'b1;
    comparator_c_address_i = 16'h1000;
    comp_c_enable_i = 1'b1;
    arm();
    cyc(16'h1000, 16'h0, 1'b0);
    tick(4);
    check("c_wins", triggered_o, 1'h0);
    check("c_flag", flag_c_o, 1'h1);
    check("c_break", brk_seen, 1'h1);
    comp_c_enable_i = 1'b0;
    arm();
    cyc(16'h1000, 16'h0, 1'b0);
    check("tag_wait", triggered_o, 1'h0);
    tick(4);
    check("tag_trig", triggered_o, 1'h1);
    comp_a_rw_qualify_enable_i = 1'b0;
    trigger_mode_i = 4'h3;
    arm();
    cyc(16'h2000, 16'h1234);
    check("ev_trig", triggered_o, 1'h1);
    check("ev_armed", armed_o, 1'h1);
    cyc(16'h2000, 16'h5678);
    tick(2);
    check("ev_data", last_store, 16'h5678);
    tag_select_i = 1'b0;
    trigger_mode_i = 4'h4;
    arm();
    cyc(16'h2000, 16'h1111);
    check("aeb_early", flag_b_o, 1'h0);
    cyc(16'h1000);
    cyc(16'h2000, 16'h9abc);
    check("aeb_data", last_store, 16'h9abc);
    check("aeb_armed", armed_o, 1'h1);
    arm_clear_i = 1'b1;
    tick(1);
    arm_clear_i = 1'b0;
    check("disarm", armed_o, 1'h0);
    capture_mode_i = 2'h2;
    trigger_mode_i = 4'h3;
    arm();
    cyc(16'h1234, 16'h5678);
    tick(1);
    check("det_count", store_count_o, 7'h02);
    check("det_data", last_store, 16'h5678);
    cyc(16'h2000);
    check("det_end", armed_o, 1'h0);
    capture_mode_i = 2'h0;
    trigger_mode_i = 4'h0;
    arm();
    flows(70);
    check("end_count", store_count_o, 7'h40);
    check("end_full", buffer_full_o, 1'h1);
    check("end_ptr", store_ptr_o, 6'h05);
    check("end_armed", armed_o, 1'h1);
    cyc(16'h1000);
    check("end_stop", armed_o, 1'h0);
    begin_select_i = 1'b1;
    break_enable_i = 1'b1;
    arm();
    cyc(16'h1000);
    flows(70);
    check("beg_count", store_count_o, 7'h40);
    check("beg_ptr", store_ptr_o, 6'h3f);
    check("beg_disarm", armed_o, 1'h0);
    check("beg_break", brk_seen, 1'h1);
    wrap_up();
  end
endmodule // debug_trigger_comparators_tb
